// file: clock_gate_pkg.sv
// Constants for the peripheral clock gate controller
package clock_gate_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ctrl1_offset   = 12'h000;
  localparam logic [11:0] present_offset = 12'h004;
  localparam logic [11:0] active_offset  = 12'h008;
  localparam logic [15:0] ctrl1_reset    = 16'h0000;
  localparam logic [11:0] addr_reset     = 12'h000;
  localparam logic [15:0] enable_reset   = 16'h0000;
  localparam logic [31:0] rdata_reset    = 32'h0000_0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int timer5_gate_off     = 15;
  localparam int timer4_gate_off     = 14;
  localparam int timer3_gate_off     = 13;
  localparam int timer2_gate_off     = 12;
  localparam int timer1_gate_off     = 11;
  localparam int encoder_gate_off    = 10;
  localparam int pulse_gen_gate_off  = 9;
  localparam int twowire_gate_off    = 7;
  localparam int serial2_gate_off    = 6;
  localparam int serial1_gate_off    = 5;
  localparam int sport2_gate_off     = 4;
  localparam int sport1_gate_off     = 3;
  localparam int canbus_gate_off     = 1;
  localparam int converter_gate_off  = 0;

  // Implemented bits; 8 and 2 are absent
  localparam logic [15:0] impl_mask       = 16'hfefb;
  localparam logic [15:0] present_default = 16'hfefb;

  // ****************************************
  // Timing
  // ****************************************
  localparam int gate_latency_cycles = 1;

  typedef enum logic [1:0]
  {
    ahb_idle   = 2'b00,
    ahb_busy   = 2'b01,
    ahb_nonseq = 2'b10,
    ahb_seq    = 2'b11
  } htrans_type;

endpackage : clock_gate_pkg

// file: gate_stage.sv
// One instruction-cycle delay stage for a vector of clock enables
module gate_stage
(
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Enables
  input  wire logic [15:0] enable_in,
  output logic      [15:0] enable_out
);

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          enable_out[i] <= clock_gate_pkg::enable_reset[i];
        else if (ce)
          enable_out[i] <= enable_in[i];
      end
    end
  endgenerate

endmodule : gate_stage

// file: peripheral_clock_gate_ctrl.sv
// Peripheral clock gate controller with AHB-Lite register access
module peripheral_clock_gate_ctrl
#(
  parameter logic [15:0] present_mask = clock_gate_pkg::present_default
)
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Peripheral side
  output logic      [15:0] periph_clk_en,
  output logic      [15:0] periph_reg_access_en
);

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [11:0] addr_reg;
  logic        take;

  assign take = hsel && hready && htrans[1];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= clock_gate_pkg::addr_reset;
    end
    else if (ce)
    begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take)
        addr_reg <= haddr;
    end
  end

  // ****************************************
  // Disable register write decode
  // ****************************************
  logic        ctrl1_wr_hit;
  logic [15:0] ctrl1_wdata;

  // Data phase of a taken write to the disable register
  assign ctrl1_wr_hit = ce && wr_pend_reg && (addr_reg == clock_gate_pkg::ctrl1_offset);

  // Unimplemented bits never store, so they read zero
  assign ctrl1_wdata = hwdata[15:0] & clock_gate_pkg::impl_mask;

  // ****************************************
  // Disable register
  // ****************************************
  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl1_view;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ctrl1_reg <= clock_gate_pkg::ctrl1_reset;
    else if (ctrl1_wr_hit)
      ctrl1_reg <= ctrl1_wdata;
  end

  // A read taken in the data phase of a write to this register sees the new
  // bits, so a back-to-back write and read never return the stale value
  assign ctrl1_view = ctrl1_wr_hit ? ctrl1_wdata : ctrl1_reg;

  // ****************************************
  // Enable computation and delay
  // ****************************************
  logic [15:0] enable_next;
  logic [15:0] enable_reg;

  // A 1 disables; absent peripherals stay off regardless
  assign enable_next = ~ctrl1_reg & present_mask & clock_gate_pkg::impl_mask;

  // Bit written at edge N, enable changes at edge N+1: one cycle of latency
  gate_stage u_stage
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .enable_in  (enable_next),
    .enable_out (enable_reg)
  );

  // Clock enables for the glitch-free gate cells in each peripheral
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      periph_clk_en <= clock_gate_pkg::enable_reset;
    else if (ce)
      periph_clk_en <= enable_next;
  end

  // Register port of each peripheral drops writes and returns garbage when gated
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      periph_reg_access_en <= clock_gate_pkg::enable_reset;
    else if (ce)
      periph_reg_access_en <= enable_next;
  end

  // ****************************************
  // Read data and response
  // ****************************************
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (haddr)
      clock_gate_pkg::ctrl1_offset:   rdata_next = {16'h0000, ctrl1_view};
      clock_gate_pkg::present_offset: rdata_next = {16'h0000, present_mask};
      clock_gate_pkg::active_offset:  rdata_next = {16'h0000, enable_reg};
      default:                        rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      hrdata <= clock_gate_pkg::rdata_reset;
    else if (ce && take && !hwrite)
      hrdata <= rdata_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : peripheral_clock_gate_ctrl

// file: clock_gate_props.sv
// Checker for the peripheral clock gate controller
module clock_gate_props #(parameter logic [15:0] present_mask = 16'hfefb)
(
  input wire logic mclk, rst_n, ce, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [11:0] haddr,
  input wire logic [31:0] hwdata, hrdata,
  input wire logic [15:0] periph_clk_en, periph_reg_access_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire tk = hsel && hready && htrans[1] && ce;
  wire [15:0] wlo = hwdata[15:0];
  a_en_pair: assert property (periph_clk_en == periph_reg_access_en)
    else $error("enable pair split");
  a_absent_off: assert property (
    (periph_clk_en & ~(present_mask & 16'hfefb)) == 16'h0)
    else $error("absent enabled");
  a_gate_delay: assert property (tk && hwrite && haddr == 12'h0 ##1 ce[*3] |->
    periph_clk_en == (~$past(wlo, 2) & present_mask & 16'hfefb)) else $error("gate latency");
  a_freeze_ce: assert property (!ce |=> $stable(periph_clk_en)) else $error("moved frozen");
  a_ready_okay: assert property (hreadyout && !hresp) else $error("not ready");
  // Reset is the antecedent here, so this one must not be disabled by it
  a_reset_up: assert property (disable iff (1'b0) !rst_n ##1 rst_n && ce |=>
    periph_clk_en == present_mask) else $error("reset enables");
  a_unmapped_zero: assert property (tk && !hwrite && haddr > 12'h008 |=> hrdata == 32'h0)
    else $error("unmapped data");
  a_hold_data: assert property (!(tk && !hwrite) |=> $stable(hrdata)) else $error("data moved");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper bits");
  a_status_live: assert property (tk && !hwrite && haddr == 12'h008 |=>
    hrdata == {16'h0, $past(periph_clk_en)}) else $error("status mismatch");
  a_present_read: assert property (tk && !hwrite && haddr == 12'h004 |=>
    hrdata == {16'h0, present_mask}) else $error("presence mismatch");
  a_fwd_read: assert property ((tk && hwrite && haddr == 12'h0) ##1
    (tk && !hwrite && haddr == 12'h0) |=> hrdata == {16'h0, $past(wlo) & 16'hfefb})
    else $error("stale readback");
  c_write: cover property (tk && hwrite);
  c_gated: cover property (!periph_clk_en[11]);
  c_frozen: cover property (!ce);
  c_back_to_back: cover property ((tk && hwrite) ##1 (tk && !hwrite));
endmodule : clock_gate_props
bind peripheral_clock_gate_ctrl clock_gate_props #(.present_mask(present_mask)) props
(
  .mclk                 (mclk),
  .rst_n                (rst_n),
  .ce                   (ce),
  .hsel                 (hsel),
  .hwrite               (hwrite),
  .hready               (hready),
  .hreadyout            (hreadyout),
  .hresp                (hresp),
  .htrans               (htrans),
  .haddr                (haddr),
  .hwdata               (hwdata),
  .hrdata               (hrdata),
  .periph_clk_en        (periph_clk_en),
  .periph_reg_access_en (periph_reg_access_en)
);

// file: periph_model.sv
// Peripheral stand-in that counts only on allowed clocks
module periph_model
(
  input wire logic mclk, clk_en,
  output logic [7:0] ticks
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ticks = 8'h0;
  always @(posedge mclk) if (clk_en) ticks <= ticks + 8'h1;
endmodule : periph_model

// file: peripheral_clock_gate_ctrl_tb.sv
// Bench for the peripheral clock gate controller
module peripheral_clock_gate_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, ce = 1, hsel = 0, hwrite = 0, rdy, hresp;
  logic [1:0] htrans = 0;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0, hrdata, q;
  logic [15:0] en, acc, prev = 16'hfefb;
  logic [7:0] ticks, t;
  int num_errors = 0, check_count = 0;
  // Written value beside the enables it should leave
  // Rows 2 and 4 re-enable the pulse generator
  logic [15:0] rows [4][2] = '{'{16'hffff, 16'h0}, '{16'h0104, 16'hfefb},
    '{16'h0a01, 16'hf4fa}, '{16'h0, 16'hfefb}};
  peripheral_clock_gate_ctrl dut (.mclk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp,
    .periph_clk_en(en), .periph_reg_access_en(acc));
  periph_model timer1 (.mclk, .clk_en(en[11]), .ticks);
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge mclk); while (rdy !== 1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (rdy !== 1);
    q = hrdata;
  endtask : bus
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial forever #25 mclk = ~mclk;
  initial begin repeat (2000) @(posedge mclk); num_errors++; test_done; end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    repeat (2) @(posedge mclk);
    #1 chk("en", 16'hfefb, en);
    foreach (rows[i])
    begin
      bus(1, 12'h0, {16'h0, rows[i][0]});
      #1 chk("early", prev, en);
      @(posedge mclk) #1 chk("en", rows[i][1], en);
      chk("acc", rows[i][1], acc);
      bus(0, 12'h0, 0); chk("ctrl", ~rows[i][1] & 16'hfefb, q);
      bus(0, 12'h008, 0); chk("status", rows[i][1], q);
      prev = rows[i][1];
    end
    chk("resp", 0, hresp);
    // A gated timer must not see a single edge
    bus(1, 12'h0, 32'h0800); repeat (2) @(posedge mclk); t = ticks;
    repeat (5) @(posedge mclk); chk("ticks", t, ticks);
    ce <= 0; bus(1, 12'h0, 0); #1 chk("frozen", 16'hf6fb, en);
    ce <= 1; bus(1, 12'h004, 0); bus(1, 12'h00c, 32'hffff);
    bus(0, 12'h004, 0); chk("present", 16'hfefb, q);
    bus(0, 12'h00c, 0); chk("unmapped", 0, q);
    bus(0, 12'h0, 0); chk("kept", 16'h0800, q);
    // Read issued in the write's data phase must already see the new bits
    hsel <= 1; htrans <= 2'h2; hwrite <= 1; haddr <= 0;
    do @(posedge mclk); while (rdy !== 1);
    hwrite <= 0; hwdata <= 32'h8000;
    do @(posedge mclk); while (rdy !== 1);
    hsel <= 0; htrans <= 2'h0;
    do @(posedge mclk); while (rdy !== 1);
    chk("readback", 32'h8000, hrdata);
    rst_n <= 0; repeat (2) @(posedge mclk); rst_n <= 1;
    bus(0, 12'h0, 0); chk("ctrl", 0, q);
    chk("en", 16'hfefb, en);
    test_done;
  end
endmodule : peripheral_clock_gate_ctrl_tb
